/* rtl/spi_eeprom_write_guard.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Sample every input bit on rising clock
// - Count bits; misaligned deselect suppresses write
// - Writes need the enable latch set first
// - Invalid instruction: rest of frame ignored until deselect
// - Block protect: none, quarter, half, three quarters
// - Inhibit input low rejects all writes
// - Inhibit during write aborts the cycle
// - Count clocks, abandon overlong write
// - Frame starts on select low, bytes
// - Status with busy bit readable
// - Write cycle ends within 10 ms
module spi_eeprom_write_guard
  import spi_guard_pkg::*;
#(
  parameter int unsigned WRITE_MAX_CYCLES = WRITE_MAX_CYC,
  parameter bit          ABORT_ON_INHIBIT = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  input  wire logic              write_inhibit_input,
  input  wire logic              prog_ack,
  output logic                   miso,
  output logic                   miso_oe,
  output logic                   prog_en,
  output logic [ADDR_W-1:0]      prog_addr,
  output logic [7:0]             prog_data,
  output status_t                status,
  output logic                   write_aborted
);
  if (WRITE_MAX_CYCLES < 2) begin : g_bad_max
    $error("WRITE_MAX_CYCLES below 2");
  end

  // ==========================================================
  // Link side: bit and byte counting, cleared by deselect
  logic [2:0]       bit_q;
  logic [1:0]       byte_q;
  logic [6:0]       shift_q;
  logic             rdsr_q;
  frame_t           frame_q;
  status_t          stat_m_q, stat_s_q;
  logic [7:0]       rx_byte;
  logic [7:0]       sr_byte;

  assign rx_byte = {shift_q, mosi};
  // Status byte as the host sees it, busy flag in bit 0
  assign sr_byte = {4'h0, stat_s_q.bp, stat_s_q.wel, stat_s_q.wip};

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_q   <= '0;
      byte_q  <= BYTE_OP;
      shift_q <= '0;
    end else begin
      shift_q <= rx_byte[6:0];
      bit_q   <= bit_q + 3'h1;
      if (bit_q == BIT_LAST && byte_q != BYTE_SAT) begin
        byte_q <= byte_q + 2'h1;
      end
    end
  end

  // Frame summary is not cleared by deselect so the core can read it
  // after the clock has stopped; it is static while select is high.
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      frame_q <= '0;
    end else begin
      frame_q.aligned <= (bit_q == BIT_LAST);
      if (bit_q == '0 && byte_q == BYTE_OP) begin
        frame_q.cmd      <= CMD_NONE;
        frame_q.complete <= 1'b0;
      end else if (bit_q == BIT_LAST && frame_q.cmd != CMD_BAD) begin
        case (byte_q)
          BYTE_OP: begin
            case (rx_byte)
              OP_WREN:  frame_q.cmd <= CMD_WREN;
              OP_WRDI:  frame_q.cmd <= CMD_WRDI;
              OP_WRSR:  frame_q.cmd <= CMD_WRSR;
              OP_WRITE: frame_q.cmd <= CMD_WRITE;
              OP_READ:  frame_q.cmd <= CMD_READ;
              OP_RDSR:  frame_q.cmd <= CMD_RDSR;
              default:  frame_q.cmd <= CMD_BAD;
            endcase
          end
          BYTE_ARG: begin
            frame_q.addr <= rx_byte;
            frame_q.data <= rx_byte;
            if (frame_q.cmd == CMD_WRSR) frame_q.complete <= 1'b1;
          end
          BYTE_DATA: begin
            if (frame_q.cmd == CMD_WRITE) begin
              frame_q.data     <= rx_byte;
              frame_q.complete <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Status crosses as a level; two edges of the opcode byte settle it
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      stat_m_q <= '0;
      stat_s_q <= '0;
    end else begin
      stat_m_q <= status;
      stat_s_q <= stat_m_q;
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rdsr_q <= 1'b0;
    end else if (bit_q == BIT_LAST && byte_q == BYTE_OP) begin
      rdsr_q <= (rx_byte == OP_RDSR);
    end
  end

  // Output shifts on the falling edge, half a clock ahead of sampling
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= rdsr_q;
      miso    <= rdsr_q && sr_byte[BIT_LAST - bit_q];
    end
  end

  // ==========================================================
  // Core side: synchronisers
  logic cs_m_q, cs_s_q, cs_d_q;
  logic wi_m_q, wi_s_q;
  logic frame_end;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      wi_m_q <= 1'b0;
      wi_s_q <= 1'b0;
    end else begin
      cs_m_q <= cs_n;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      wi_m_q <= write_inhibit_input;
      wi_s_q <= wi_m_q;
    end
  end

  assign frame_end = cs_s_q && !cs_d_q;

  // ==========================================================
  // Core side: command execution
  logic   expired;
  logic   wr_ok, start_wr, start_sr, end_ok, end_abort;
  logic   sr_pend_q;
  logic [1:0] bp_new_q;

  assign wr_ok = frame_end && frame_q.aligned && frame_q.complete
              && status.wel && !status.wip && wi_s_q;
  assign start_wr = wr_ok && frame_q.cmd == CMD_WRITE
                 && !in_protected(status.bp, frame_q.addr);
  assign start_sr = wr_ok && frame_q.cmd == CMD_WRSR;
  assign end_ok    = status.wip && prog_ack;
  assign end_abort = status.wip && !prog_ack
                  && (expired || (ABORT_ON_INHIBIT && !wi_s_q));

  write_timer #(
    .MAX_CYCLES (WRITE_MAX_CYCLES)
  ) u_timer (
    .clk     (clk),
    .nrst    (nrst),
    .run     (status.wip),
    .expired (expired)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status.wip <= 1'b0;
      prog_en    <= 1'b0;
    end else if (start_wr || start_sr) begin
      status.wip <= 1'b1;
      prog_en    <= start_wr;
    end else if (end_ok || end_abort) begin
      status.wip <= 1'b0;
      prog_en    <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status.wel <= 1'b0;
    end else if (end_ok || end_abort) begin
      status.wel <= 1'b0;
    end else if (frame_end && frame_q.aligned && !status.wip) begin
      if (frame_q.cmd == CMD_WREN) status.wel <= 1'b1;
      if (frame_q.cmd == CMD_WRDI) status.wel <= 1'b0;
    end
  end

  // Protection bits commit only when the write completes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status.bp <= BP_RESET;
      sr_pend_q <= 1'b0;
      bp_new_q  <= BP_RESET;
    end else if (start_sr) begin
      sr_pend_q <= 1'b1;
      bp_new_q  <= frame_q.data[SR_BP_LSB +: 2];
    end else if (end_ok || end_abort) begin
      sr_pend_q <= 1'b0;
      if (end_ok && sr_pend_q) status.bp <= bp_new_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_addr     <= '0;
      prog_data     <= '0;
      write_aborted <= 1'b0;
    end else if (start_wr || start_sr) begin
      prog_addr     <= frame_q.addr;
      prog_data     <= frame_q.data;
      write_aborted <= 1'b0;
    end else if (end_abort) begin
      write_aborted <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_need_wel;
    $rose(status.wip) |-> $past(status.wel);
  endproperty
  a_need_wel: assert property (p_need_wel)
    else $error("write started without enable latch");

  property p_misaligned;
    frame_end && !frame_q.aligned |=> !$rose(status.wip);
  endproperty
  a_misaligned: assert property (p_misaligned)
    else $error("misaligned frame started a write");

  property p_inhibit;
    !wi_s_q |=> !$rose(status.wip);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("write started while inhibited");

  property p_abort;
    status.wip && !prog_ack && !wi_s_q && ABORT_ON_INHIBIT
      |=> !status.wip && write_aborted;
  endproperty
  a_abort: assert property (p_abort)
    else $error("inhibit did not abort write");

  property p_timeout;
    expired && status.wip |=> !status.wip && !prog_en;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timed out write not abandoned");

  property p_wel_clear;
    $fell(status.wip) |-> !status.wel;
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("enable latch left set after write");

  property p_protect;
    frame_end && frame_q.cmd == CMD_WRITE && status.bp != 2'h0
      && ({1'b0, frame_q.addr[ADDR_W-1 -: 2]} + {1'b0, status.bp}
          >= QUARTERS) |=> !$rose(status.wip);
  endproperty
  a_protect: assert property (p_protect)
    else $error("write into protected block");

  property p_bad_cmd;
    frame_end && frame_q.cmd == CMD_BAD |=> !$rose(status.wip)
      && !$rose(status.wel);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("invalid instruction had an effect");

  property p_busy_flag;
    prog_en |-> status.wip;
  endproperty
  a_busy_flag: assert property (p_busy_flag)
    else $error("programming without busy flag");

  c_write_done: cover property (start_wr ##[1:1000] end_ok);
  c_write_abort: cover property (start_wr ##[1:1000] end_abort);
  c_sr_write: cover property (start_sr ##[1:1000] end_ok);

endmodule : spi_eeprom_write_guard
`default_nettype wire

/* rtl/spi_guard_pkg.sv */
package spi_guard_pkg;

  // ==========================================================
  // Instruction codes
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WREN  = 8'h06;

  // ==========================================================
  // Framing and layout
  localparam int          BYTE_BITS  = 8;
  localparam int          ADDR_W     = 8;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [1:0]  BYTE_OP    = 2'h0;
  localparam logic [1:0]  BYTE_ARG   = 2'h1;
  localparam logic [1:0]  BYTE_DATA  = 2'h2;
  localparam logic [1:0]  BYTE_SAT   = 2'h3;
  localparam int          SR_WIP     = 0;
  localparam int          SR_WEL     = 1;
  localparam int          SR_BP_LSB  = 2;
  localparam logic [1:0]  BP_RESET   = 2'h0;
  localparam logic [2:0]  QUARTERS   = 3'h4;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_MAX_US  = 10000;
  localparam int WRITE_MAX_CYC = WRITE_MAX_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_WREN, CMD_WRDI, CMD_WRSR,
    CMD_WRITE, CMD_READ, CMD_RDSR, CMD_BAD
  } cmd_t;

  typedef struct packed {
    cmd_t              cmd;
    logic              aligned;
    logic              complete;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } frame_t;

  typedef struct packed {
    logic       wip;
    logic       wel;
    logic [1:0] bp;
  } status_t;

  // Protected area grows down from the top of the array
  function automatic logic in_protected(input logic [1:0]        bp,
                                        input logic [ADDR_W-1:0] addr);
    logic [2:0] top;
    top = {1'b0, addr[ADDR_W-1 -: 2]};
    return (bp != 2'h0) && (top >= (QUARTERS - {1'b0, bp}));
  endfunction : in_protected

endpackage : spi_guard_pkg

/* rtl/write_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module write_timer #(
  parameter int unsigned MAX_CYCLES = 2500000
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      expired
);
  localparam int CW = $clog2(MAX_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(MAX_CYCLES - 1);

  if (MAX_CYCLES < 2) begin : g_bad_max
    $error("write_timer: MAX_CYCLES below 2");
  end

  logic [CW-1:0] cnt_q;

  // ==========================================================
  // Clock counting while a write is running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      expired <= 1'b0;
    end else begin
      expired <= run && (cnt_q == LAST);
    end
  end
endmodule : write_timer
`default_nettype wire

/* test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host master, link clock idles low between frames
module host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic seen_oe;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    seen_oe = 1'b0;
  end

  // MSB first; data moves only while sck is low
  task automatic xfer(input logic [31:0] d, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    seen_oe = 1'b0;
    // Odd offset keeps link edges off the core clock edges
    #7.3;
    cs_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #40 sck = 1'b1;
      rx = {rx[6:0], miso};
      seen_oe = seen_oe | miso_oe;
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    mosi = ~mosi;
    #40;
  endtask : xfer
endmodule : host_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spi_guard_pkg::*;
  // ==========================================================
  // Signals
  logic              clk;
  logic              nrst;
  logic              sck;
  logic              cs_n;
  logic              mosi;
  logic              write_inhibit_input;
  logic              prog_ack;
  logic              ack_on;
  logic              miso;
  logic              miso_oe;
  logic              prog_en;
  logic              prog_en_q;
  logic [ADDR_W-1:0] prog_addr;
  logic [7:0]        prog_data;
  status_t           status;
  logic              write_aborted;
  logic [7:0]        rx;
  logic [15:0]       exp_q[$];
  int                num_errors = 0;
  int                checked = 0;

  // Short timeout so the abandon path runs in about 50 cycles
  spi_eeprom_write_guard #(
    .WRITE_MAX_CYCLES(50),
    .ABORT_ON_INHIBIT(1'b1)
  ) uut (
    .clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .write_inhibit_input(write_inhibit_input), .prog_ack(prog_ack),
    .miso(miso), .miso_oe(miso_oe), .prog_en(prog_en),
    .prog_addr(prog_addr), .prog_data(prog_data), .status(status),
    .write_aborted(write_aborted)
  );

  host_model host (
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // Cell array stand-in and write monitor
  // Array acks data and status programming alike, one cycle in
  always @(negedge clk) begin
    prog_ack <= status.wip & ack_on;
  end

  // Sampled away from the launching edge so the outputs are settled
  always @(negedge clk) begin
    if (prog_en === 1'b1 && prog_en_q !== 1'b1) begin
      chk("write_wanted", 16'h1, 16'(exp_q.size() != 0));
      if (exp_q.size() != 0) begin
        chk("write", exp_q.pop_front(), {prog_addr, prog_data});
      end
    end
    prog_en_q <= prog_en;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic frame(input logic [31:0] d, input int n);
    host.xfer(d, n, rx);
    @(negedge clk);
  endtask : frame

  task automatic idle();
    for (int i = 0; i < 300 && status.wip !== 1'b0; i++) begin
      @(negedge clk);
    end
    chk("wip_idle", 16'h0, 16'(status.wip));
  endtask : idle

  task automatic start(input logic [7:0] a, input logic [7:0] d,
                       input bit e);
    if (e) begin
      exp_q.push_back({a, d});
    end
    frame(OP_WREN, 8);
    frame({OP_WRITE, a, d}, 24);
  endtask : start

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input bit e);
    start(a, d, e);
    idle();
    if (e) begin
      chk("wel_clear", 16'h0, 16'(status.wel));
    end
  endtask : wr

  task automatic test_done();
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // Scenarios
  initial begin
    nrst = 1'b0;
    write_inhibit_input = 1'b0;
    ack_on = 1'b1;
    void'($urandom(68));
    tick(8);
    nrst = 1'b1;
    tick(3);
    chk("status_rst", 16'h0, 16'(status));
    wr(8'h10, 8'($urandom), 1'b0);
    write_inhibit_input = 1'b1;
    tick(4);
    frame(OP_WRDI, 8);
    frame({OP_WRITE, 16'h1055}, 24);
    idle();
    frame(OP_WREN, 8);
    frame({OP_WRITE, 8'h20, 7'h25}, 23);
    idle();
    frame(OP_WRDI, 8);
    frame({8'hFF, OP_WREN}, 16);
    chk("wel_bad", 16'h0, 16'(status.wel));
    chk("oe_bad", 16'h0, 16'(host.seen_oe));
    frame(OP_WREN, 8);
    frame({OP_RDSR, 8'h00}, 16);
    chk("rdsr", 16'h02, 16'(rx));
    chk("oe_rdsr", 16'h1, 16'(host.seen_oe));
    for (int b = 0; b < 4; b++) begin
      frame(OP_WREN, 8);
      frame({OP_WRSR, 4'h0, 2'(b), 2'h0}, 16);
      idle();
      chk("bp", 16'(b), 16'(status.bp));
      for (int q = 0; q < 4; q++) begin
        wr({2'(q), 6'($urandom)}, 8'($urandom), b == 0 || q < 4 - b);
      end
    end
    frame(OP_WREN, 8);
    frame({OP_WRSR, 8'h00}, 16);
    idle();
    ack_on = 1'b0;
    start(8'h11, 8'h3C, 1'b1);
    chk("prog_en_on", 16'h1, 16'(prog_en));
    write_inhibit_input = 1'b0;
    tick(8);
    chk("aborted", 16'h1, 16'(write_aborted));
    chk("prog_en_off", 16'h0, 16'(prog_en));
    chk("wel_abort", 16'h0, 16'(status.wel));
    write_inhibit_input = 1'b1;
    tick(4);
    start(8'h22, 8'hC3, 1'b1);
    chk("abort_clr", 16'h0, 16'(write_aborted));
    tick(30);
    chk("wip_run", 16'h1, 16'(status.wip));
    tick(40);
    chk("timeout", 16'h1, 16'(write_aborted));
    chk("wip_to", 16'h0, 16'(status.wip));
    chk("pending", 16'h0, 16'(exp_q.size()));
    test_done();
  end

  // Normal run is near 20k cycles; this bound is 50k cycles
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
